// *** read_latency_pkg.sv ***
// constants of the read latency table and the padding parameter
package read_latency_pkg;
  // ----------------------------------------------------------------
  // table layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam logic [7:0] LAT_PARAM_ID = 8'h90;
  localparam logic [7:0] LAT_PARAM_LEN = 8'h56;
  localparam logic [7:0] ROW_COUNT = 8'h06;
  localparam logic [7:0] ROW_LEN = 8'h0e;
  localparam logic [6:0] ROW0_BASE = 7'h04;
  localparam logic [6:0] PAD_BASE = 7'h58;
  localparam logic [7:0] PAD_ID = 8'hf0;
  localparam logic [7:0] PAD_LEN = 8'h0f;
  localparam logic [7:0] PAD_FILL = 8'hff;
  localparam logic [6:0] PAD_NEXT = 7'h69;
  localparam logic [7:0] NOT_SUPPORTED = 8'hff;
  localparam logic [6:0] ROW_BASE [0:5] = '{7'h04, 7'h12, 7'h20, 7'h2e,
    7'h3c, 7'h4a};
  localparam logic [7:0] ROWS [0:5][0:13] = '{
    '{8'h46, 8'h43, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b,
      8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec},
    '{8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h04, 8'h00, 8'h02, 8'h01},
    '{8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h04, 8'h00, 8'h02, 8'h04},
    '{8'h5a, 8'h01, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h04, 8'h01, 8'h02, 8'h04},
    '{8'h68, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00,
      8'h08, 8'h04, 8'h02, 8'h02, 8'h05},
    '{8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff}};
  // ----------------------------------------------------------------
  // latency codes, rows, columns, read kinds and sequencer states
  // ----------------------------------------------------------------
  localparam logic [1:0] CODE_80 = 2'h0;
  localparam logic [1:0] CODE_90 = 2'h1;
  localparam logic [1:0] CODE_108 = 2'h2;
  localparam logic [1:0] CODE_50 = 2'h3;
  localparam logic [2:0] ROW_50 = 3'h1;
  localparam logic [2:0] ROW_80 = 3'h2;
  localparam logic [2:0] ROW_90 = 3'h3;
  localparam logic [2:0] ROW_108 = 3'h4;
  localparam logic [2:0] ROW_133 = 3'h5;
  localparam logic [6:0] COL_MODE = 7'h02;
  localparam logic [6:0] COL_LAT = 7'h03;
  typedef enum logic [2:0] {
    RD_BASIC = 3'h0, RD_FAST = 3'h1, RD_DUAL_OUT = 3'h2,
    RD_QUAD_OUT = 3'h3, RD_DUAL_IO = 3'h4, RD_QUAD_IO = 3'h5
  } read_kind_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_MODE = 4'b0010, ST_DUMMY = 4'b0100,
    ST_DATA = 4'b1000
  } seq_state_t;
endpackage : read_latency_pkg

// *** latency_rom.sv ***
// byte rom of the latency code parameter and the padding parameter
`timescale 1ns/10ps
`default_nettype none
module latency_rom (
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  logic [2:0] row;
  logic [6:0] col;

  // ----------------------------------------------------------------
  // row decode by base compare, avoids a divide by fourteen
  // ----------------------------------------------------------------
  always_comb begin
    row = 3'h0;
    for (int i = 1; i < 6; i++) begin
      if (addr >= read_latency_pkg::ROW_BASE[i]) begin
        row = 3'(i);
      end
    end
    col = 7'(addr - read_latency_pkg::ROW_BASE[row]);
  end

  always_comb begin
    if (addr == 7'h00) begin
      data = read_latency_pkg::LAT_PARAM_ID;
    end else if (addr == 7'h01) begin
      data = read_latency_pkg::LAT_PARAM_LEN;
    end else if (addr == 7'h02) begin
      data = read_latency_pkg::ROW_COUNT;
    end else if (addr == 7'h03) begin
      data = read_latency_pkg::ROW_LEN;
    end else if (addr < read_latency_pkg::PAD_BASE) begin
      data = read_latency_pkg::ROWS[row][col[3:0]];
    end else if (addr == read_latency_pkg::PAD_BASE) begin
      data = read_latency_pkg::PAD_ID;
    end else if (addr == 7'(read_latency_pkg::PAD_BASE + 7'h01)) begin
      data = read_latency_pkg::PAD_LEN;
    end else begin
      data = read_latency_pkg::PAD_FILL;
    end
  end
endmodule : latency_rom
`default_nettype wire

// *** read_latency_table.sv ***
// read latency lookup, phase sequencer and table byte reads
`timescale 1ns/10ps
`default_nettype none
module read_latency_table (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] lat_code,
  input wire logic high_rate,
  input wire logic cmd_start,
  input wire logic [2:0] cmd_kind,
  input wire logic sck_edge,
  input wire logic cmd_end,
  input wire logic [6:0] tbl_addr,
  output logic [7:0] tbl_data,
  output logic mode_phase,
  output logic dummy_phase,
  output logic data_drive,
  output logic cmd_reject,
  output logic [7:0] mode_cycles,
  output logic [7:0] lat_cycles
);
  // ----------------------------------------------------------------
  // row selection from the latency code
  // ----------------------------------------------------------------
  logic [2:0] row_sel;
  logic [6:0] mode_addr;
  logic [6:0] lat_addr;
  logic [7:0] mode_byte;
  logic [7:0] lat_byte;
  logic [7:0] tbl_byte;

  always_comb begin
    unique case (lat_code)
      read_latency_pkg::CODE_50: row_sel = read_latency_pkg::ROW_50;
      read_latency_pkg::CODE_80: row_sel = read_latency_pkg::ROW_80;
      read_latency_pkg::CODE_90: row_sel = read_latency_pkg::ROW_90;
      // one code, two rows: the clock rate picks which
      read_latency_pkg::CODE_108: row_sel = high_rate ?
        read_latency_pkg::ROW_133 : read_latency_pkg::ROW_108;
    endcase
    mode_addr = 7'(read_latency_pkg::ROW_BASE[row_sel] +
      read_latency_pkg::COL_MODE + {3'h0, cmd_kind, 1'b0});
    lat_addr = 7'(read_latency_pkg::ROW_BASE[row_sel] +
      read_latency_pkg::COL_LAT + {3'h0, cmd_kind, 1'b0});
  end

  latency_rom u_mode_rom (
    .addr(mode_addr),
    .data(mode_byte)
  );
  latency_rom u_lat_rom (
    .addr(lat_addr),
    .data(lat_byte)
  );
  latency_rom u_tbl_rom (
    .addr(tbl_addr),
    .data(tbl_byte)
  );

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  read_latency_pkg::seq_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] lat_q, lat_d;
  logic [7:0] mode_cyc_q, mode_cyc_d;
  logic [7:0] lat_cyc_q, lat_cyc_d;
  logic reject_q, reject_d;
  logic [7:0] tbl_q;
  logic bad_kind;
  logic unsupported;

  always_comb begin
    bad_kind = cmd_kind > 3'(read_latency_pkg::RD_QUAD_IO);
    unsupported = bad_kind ||
      mode_byte == read_latency_pkg::NOT_SUPPORTED ||
      lat_byte == read_latency_pkg::NOT_SUPPORTED;
    state_d = state_q;
    cnt_d = cnt_q;
    lat_d = lat_q;
    mode_cyc_d = mode_cyc_q;
    lat_cyc_d = lat_cyc_q;
    reject_d = 1'b0;
    unique case (state_q)
      read_latency_pkg::ST_IDLE: begin
        if (cmd_start) begin
          if (unsupported) begin
            reject_d = 1'b1;
          end else begin
            mode_cyc_d = mode_byte;
            lat_cyc_d = lat_byte;
            cnt_d = mode_byte;
            lat_d = lat_byte;
            if (mode_byte != 8'h00) begin
              state_d = read_latency_pkg::ST_MODE;
            end else if (lat_byte != 8'h00) begin
              cnt_d = lat_byte;
              state_d = read_latency_pkg::ST_DUMMY;
            end else begin
              state_d = read_latency_pkg::ST_DATA;
            end
          end
        end
      end
      read_latency_pkg::ST_MODE: begin
        if (cmd_end) begin
          state_d = read_latency_pkg::ST_IDLE;
        end else if (sck_edge) begin
          cnt_d = 8'(cnt_q - 8'h01);
          if (cnt_q == 8'h01) begin
            cnt_d = lat_q;
            state_d = (lat_q != 8'h00) ? read_latency_pkg::ST_DUMMY :
              read_latency_pkg::ST_DATA;
          end
        end
      end
      read_latency_pkg::ST_DUMMY: begin
        if (cmd_end) begin
          state_d = read_latency_pkg::ST_IDLE;
        end else if (sck_edge) begin
          cnt_d = 8'(cnt_q - 8'h01);
          if (cnt_q == 8'h01) begin
            state_d = read_latency_pkg::ST_DATA;
          end
        end
      end
      read_latency_pkg::ST_DATA: begin
        if (cmd_end) begin
          state_d = read_latency_pkg::ST_IDLE;
        end
      end
      default: state_d = read_latency_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= read_latency_pkg::ST_IDLE;
      cnt_q <= 8'h00;
      lat_q <= 8'h00;
      mode_cyc_q <= 8'h00;
      lat_cyc_q <= 8'h00;
      reject_q <= 1'b0;
      tbl_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      lat_q <= lat_d;
      mode_cyc_q <= mode_cyc_d;
      lat_cyc_q <= lat_cyc_d;
      reject_q <= reject_d;
      tbl_q <= tbl_byte;
    end
  end

  assign tbl_data = tbl_q;
  assign mode_phase = state_q[1];
  assign dummy_phase = state_q[2];
  assign data_drive = state_q[3];
  assign cmd_reject = reject_q;
  assign mode_cycles = mode_cyc_q;
  assign lat_cycles = lat_cyc_q;
endmodule : read_latency_table
`default_nettype wire

// *** read_latency_chk.sv ***
// assertions on the read latency table ports
`timescale 1ns/10ps
`default_nettype none
module read_latency_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] lat_code,
  input wire logic high_rate,
  input wire logic cmd_start,
  input wire logic [2:0] cmd_kind,
  input wire logic cmd_end,
  input wire logic [6:0] tbl_addr,
  input wire logic [7:0] tbl_data,
  input wire logic mode_phase,
  input wire logic dummy_phase,
  input wire logic data_drive,
  input wire logic cmd_reject,
  input wire logic [7:0] mode_cycles,
  input wire logic [7:0] lat_cycles
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic go;
  // a start only counts while idle and not aborted in the same cycle
  assign go = cmd_start && !cmd_end &&
    !(mode_phase || dummy_phase || data_drive);
  a_bad_kind: assert property (go && cmd_kind > 3'h5 |=> cmd_reject)
    else $error("unknown read kind taken");
  a_basic_off: assert property (go && cmd_kind == 3'h0
    && lat_code != 2'h3 |=> cmd_reject)
    else $error("basic read taken in fast row");
  // back-to-back refused starts may give back-to-back rejects
  a_reject_once: assert property (cmd_reject && !go |=> !cmd_reject)
    else $error("reject longer than a cycle");
  a_fast_eight: assert property (go && cmd_kind == 3'h1
    && lat_code != 2'h3 |=> dummy_phase && lat_cycles == 8'h08
    && mode_cycles == 8'h00)
    else $error("fast read counts wrong");
  a_slow_row: assert property (go && cmd_kind < 3'h4 && lat_code == 2'h3
    |=> data_drive && lat_cycles == 8'h00) else $error("slow row not zero");
  a_top_row: assert property (go && lat_code == 2'h2 && high_rate
    && cmd_kind inside {[3'h2:3'h5]} |=> cmd_reject) else $error("top row");
  a_dual_io: assert property (go && cmd_kind == 3'h4 && lat_code == 2'h0
    |=> mode_phase && mode_cycles == 8'h04 && lat_cycles == 8'h00)
    else $error("dual io counts wrong");
  a_pad_id: assert property (tbl_addr == 7'h58 |=> tbl_data == 8'hf0)
    else $error("pad id wrong");
  a_row_limit: assert property (tbl_addr == 7'h3c |=> tbl_data == 8'h68)
    else $error("row limit wrong");
endmodule : read_latency_chk
bind read_latency_table read_latency_chk read_latency_chk_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .lat_code(lat_code),
  .high_rate(high_rate), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
  .cmd_end(cmd_end), .tbl_addr(tbl_addr), .tbl_data(tbl_data),
  .mode_phase(mode_phase), .dummy_phase(dummy_phase),
  .data_drive(data_drive), .cmd_reject(cmd_reject),
  .mode_cycles(mode_cycles), .lat_cycles(lat_cycles));
`default_nettype wire

// *** spi_host_model.sv ***
// host side model ticking the serial clock through mode and dummy
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic mode_phase,
  input wire logic dummy_phase,
  output logic sck_edge
);
  logic tick_q;
  logic tick_d;
  // clock stands still outside the mode and dummy phases; slow halves the tick rate
  always_comb begin
    tick_d = (mode_phase || dummy_phase) && !(slow && tick_q);
  end
  always_ff @(posedge clk_sys) begin
    tick_q <= tick_d;
  end
  assign sck_edge = tick_q;
endmodule : spi_host_model
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the read latency table
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] lat_code = 2'h0;
  logic high_rate = 1'b0, cmd_start = 1'b0, cmd_end = 1'b0, slow = 1'b0;
  logic [2:0] cmd_kind = 3'h0;
  logic [6:0] tbl_addr = 7'h00;
  logic [7:0] tbl_data, mode_cycles, lat_cycles;
  logic sck_edge, mode_phase, dummy_phase, data_drive, cmd_reject;
  int error_cnt = 0;
  int cmp_count = 0;
  always #20 clk_sys = ~clk_sys;
  read_latency_table read_latency_table_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .lat_code(lat_code),
    .high_rate(high_rate), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
    .sck_edge(sck_edge), .cmd_end(cmd_end), .tbl_addr(tbl_addr),
    .tbl_data(tbl_data), .mode_phase(mode_phase),
    .dummy_phase(dummy_phase), .data_drive(data_drive),
    .cmd_reject(cmd_reject), .mode_cycles(mode_cycles),
    .lat_cycles(lat_cycles));
  spi_host_model spi_host_model_inst (.clk_sys(clk_sys), .slow(slow),
    .mode_phase(mode_phase), .dummy_phase(dummy_phase),
    .sck_edge(sck_edge));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // one read; ticks are counted per phase, not trusted from the counts
  task automatic rd(input logic [1:0] code, input logic hr,
    input logic [2:0] kind, input logic [7:0] em, input logic [7:0] el,
    input logic rej);
    int nm;
    int nl;
    nm = 0;
    nl = 0;
    @(posedge clk_sys);
    lat_code <= code;
    high_rate <= hr;
    cmd_kind <= kind;
    cmd_start <= 1'b1;
    @(posedge clk_sys);
    cmd_start <= 1'b0;
    @(negedge clk_sys);
    cmp8({7'h00, cmd_reject}, {7'h00, rej});
    if (!rej) begin
      repeat (40) begin
        if (data_drive) break;
        nm += int'(mode_phase && sck_edge);
        nl += int'(dummy_phase && sck_edge);
        @(negedge clk_sys);
      end
      cmp8(8'(nm), em);
      cmp8(8'(nl), el);
      cmp8(mode_cycles, em);
      cmp8(lat_cycles, el);
      cmp8({7'h00, data_drive}, 8'h01);
      @(posedge clk_sys);
      cmd_end <= 1'b1;
      @(posedge clk_sys);
      cmd_end <= 1'b0;
      @(negedge clk_sys);
      cmp8({7'h00, data_drive}, 8'h00);
    end
  endtask : rd
  task automatic test_table;
    logic [6:0] a [0:9] = '{7'h2e, 7'h3c, 7'h4a, 7'h2f, 7'h3d, 7'h4b,
      7'h58, 7'h59, 7'h5a, 7'h68};
    logic [7:0] e [0:9] = '{8'h5a, 8'h68, 8'h85, 8'h01, 8'h02, 8'h02,
      8'hf0, 8'h0f, 8'hff, 8'hff};
    foreach (a[i]) begin
      @(posedge clk_sys);
      tbl_addr <= a[i];
      @(posedge clk_sys);
      @(negedge clk_sys);
      cmp8(tbl_data, e[i]);
    end
    $display("test table done");
  endtask : test_table
  task automatic test_low_rows;
    rd(2'h3, 1'b0, 3'h5, 8'h02, 8'h01, 1'b0);
    rd(2'h3, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    rd(2'h0, 1'b0, 3'h1, 8'h00, 8'h08, 1'b0);
    rd(2'h0, 1'b0, 3'h3, 8'h00, 8'h08, 1'b0);
    rd(2'h0, 1'b0, 3'h4, 8'h04, 8'h00, 1'b0);
    rd(2'h0, 1'b0, 3'h5, 8'h02, 8'h04, 1'b0);
    rd(2'h0, 1'b0, 3'h0, 8'h00, 8'h00, 1'b1);
    $display("test low rows done");
  endtask : test_low_rows
  task automatic test_high_rows;
    @(posedge clk_sys);
    slow <= 1'b1;
    rd(2'h1, 1'b0, 3'h2, 8'h00, 8'h08, 1'b0);
    rd(2'h1, 1'b0, 3'h4, 8'h04, 8'h01, 1'b0);
    rd(2'h2, 1'b0, 3'h5, 8'h02, 8'h05, 1'b0);
    rd(2'h2, 1'b0, 3'h4, 8'h04, 8'h02, 1'b0);
    rd(2'h2, 1'b1, 3'h1, 8'h00, 8'h08, 1'b0);
    rd(2'h2, 1'b1, 3'h3, 8'h00, 8'h00, 1'b1);
    rd(2'h1, 1'b0, 3'h0, 8'h00, 8'h00, 1'b1);
    rd(2'h2, 1'b0, 3'h7, 8'h00, 8'h00, 1'b1);
    $display("test high rows done");
  endtask : test_high_rows
  // chip select rising inside the mode phase must drop back to idle
  task automatic test_abort;
    @(posedge clk_sys);
    lat_code <= 2'h0;
    high_rate <= 1'b0;
    cmd_kind <= 3'h5;
    cmd_start <= 1'b1;
    @(posedge clk_sys);
    cmd_start <= 1'b0;
    @(negedge clk_sys);
    cmp8({7'h00, mode_phase}, 8'h01);
    @(posedge clk_sys);
    cmd_end <= 1'b1;
    @(posedge clk_sys);
    cmd_end <= 1'b0;
    @(negedge clk_sys);
    cmp8({5'h00, mode_phase, dummy_phase, data_drive}, 8'h00);
    rd(2'h1, 1'b0, 3'h5, 8'h02, 8'h04, 1'b0);
    $display("test abort done");
  endtask : test_abort
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_table();
    test_low_rows();
    test_high_rows();
    test_abort();
    close_out();
  end
  // whole run needs under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    close_out();
  end
endmodule : tb
`default_nettype wire
